// ==== src/ep0c_ahb_slave.sv ====
// AHB-Lite slave front end: word registers, zero wait states, always OKAY.
// Assumes single word transfers; register contents live in the parent.
`timescale 1ns/1ps
`default_nettype none
module ep0c_ahb_slave
   import ep0c_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // AHB-Lite
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // Register side
   output ep0c_wr_s wr_o,
   output logic [7:0] rd_idx_o,
   input wire logic [31:0] rd_data_i
);
   logic take;
   logic wpend_ff;
   logic [7:0] widx_ff;
   logic [31:0] hrdata_ff;

   // Only non-sequential word transfers are expected
   assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);
   assign rd_idx_o = haddr_i[9:2];
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_ff;
   assign wr_o = '{vld: wpend_ff, idx: widx_ff, data: hwdata_i};

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wpend_ff <= 1'b0;
         widx_ff <= 8'h00;
      end else begin
         wpend_ff <= take && hwrite_i && (haddr_i[31:10] == 22'h000000);
         if (take) begin
            widx_ff <= haddr_i[9:2];
         end
      end
   end

   // Read data is sampled at the address phase so it stands in the data phase
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         hrdata_ff <= 32'h00000000;
      end else if (take && !hwrite_i) begin
         hrdata_ff <= (haddr_i[31:10] == 22'h000000) ? rd_data_i : 32'h00000000;
      end
   end
endmodule : ep0c_ahb_slave
`default_nettype wire

// ==== src/ep0c_consts.svh ====
// Register indices, bit positions, reset values of the endpoint 0 control block.
// Included by the control module and by the testbench.
`ifndef EP0C_CONSTS_SVH
`define EP0C_CONSTS_SVH
// Register indices; byte address is four times the index
`define EP0C_IDX_DIR_DESC 8'h41
`define EP0C_IDX_IN_HS 8'h42
`define EP0C_IDX_OUT_HS 8'h43
`define EP0C_IDX_DESC_PTR 8'h70
`define EP0C_IDX_DESC_SIZE 8'h71
`define EP0C_IDX_FLAGS 8'h72
// Field positions
`define EP0C_B_DIR 7
`define EP0C_B_REPLY 0
`define EP0C_B_SHORT 6
`define EP0C_B_AUTONAK 7
`define EP0C_B_SEQ 4
`define EP0C_B_SEQ_ONE 3
`define EP0C_B_SEQ_ZERO 2
`define EP0C_B_NAK 1
`define EP0C_B_STALL 0
`define EP0C_B_DONE 0
`define EP0C_B_INACK 1
// Reset values
`define EP0C_RST_DIR_DESC 8'h00
`define EP0C_RST_IN_HS 8'h00
`define EP0C_RST_OUT_HS 8'h00
`define EP0C_RST_DESC 16'h0000
`endif

// ==== src/ep0c_ctrl.sv ====
// Endpoint 0 control: direction, descriptor reply, short packets, sequence
// bits, forced NAK and STALL. Assumes a USB engine on the same clock that
// reports tokens and transaction ends as one-cycle pulses.
// Operation
// - Token against programmed direction gets NAK, or STALL when stall forced.
// - Descriptor reply answers IN with up to max packet from pointer.
// - Each acknowledged reply transaction advances pointer and shrinks remaining size.
// - Reply ends when all sent or non-IN token; flags set.
// - Short enable sends short packet, clears after short, stays after full.
// - Short enable with empty FIFO sends zero-length packet.
// - Separate IN and OUT sequence bits, each readable.
// - Sequence force-one and force-zero strobes; zero wins when both.
// - Forced NAK answers that direction with NAK regardless of FIFO.
// - Setup sets both forced NAKs; clears ignored while setup flag stands.
// - Setup clears both stall forces; sets ignored while setup flag stands.
// - Short IN packet completion sets IN forced NAK.
// - Forced NAK written during transaction takes effect at its end.
// - Stall force answers STALL, above forced NAK.
// - Stall set mid-transaction applies from next transaction.
// - Auto-NAK option sets OUT forced NAK after each good OUT.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ep0c_consts.svh"
module ep0c_ctrl
   import ep0c_pkg::*;
#(
   parameter int FIFO_CW = 12,
   parameter int DESC_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // AHB-Lite register bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // USB engine events
   input wire logic tok_i,
   input wire logic tok_in_i,
   input wire logic tok_setup_i,
   input wire logic txn_end_i,
   input wire logic txn_ok_i,
   input wire logic setup_done_i,
   input wire logic setup_flag_i,
   // FIFO and packet size
   input wire logic [6:0] ep0_packet_limit_i,
   input wire logic [FIFO_CW-1:0] fifo_count_i,
   input wire logic [FIFO_CW-1:0] fifo_free_i,
   // Answer to the engine
   output ep0c_resp_s resp_o,
   output logic busy_o,
   output logic [DESC_W-1:0] descriptor_pointer_o
);
   ep0c_wr_s wr;
   logic [7:0] rd_idx;
   logic [31:0] rd_data;
   // Reset words as constants, since a bit cannot be picked out of a bare literal
   localparam logic [7:0] RST_DIR_DESC = `EP0C_RST_DIR_DESC;
   localparam logic [7:0] RST_IN_HS = `EP0C_RST_IN_HS;
   localparam logic [7:0] RST_OUT_HS = `EP0C_RST_OUT_HS;

   ep0c_ahb_slave u_bus (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hsize_i(hsize_i),
      .hwdata_i(hwdata_i),
      .hready_i(hready_i),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .hrdata_o(hrdata_o),
      .wr_o(wr),
      .rd_idx_o(rd_idx),
      .rd_data_i(rd_data)
   );

   // Control state
   logic ep0_direction_ff;
   logic descriptor_reply_go_ff;
   logic short_packet_enable_ff;
   logic auto_nak_after_out_ff;
   logic [DESC_W-1:0] descriptor_pointer_ff;
   logic [DESC_W-1:0] descriptor_remaining_size_ff;
   logic descriptor_done_flag_ff;
   logic in_acked_flag_ff;
   // Per direction, index 1 is IN and 0 is OUT
   logic [1:0] nak_force_ff;
   logic [1:0] nak_pend_ff;
   logic [1:0] stall_force_ff;
   logic [1:0] seq_bit_state_ff;
   // Transaction in flight
   logic busy_ff;
   logic txn_in_ff;
   logic txn_setup_ff;
   ep0c_resp_s resp_ff;
   ep0c_resp_s nxt_resp;

   function automatic logic hit(input ep0c_wr_s w, input logic [7:0] idx);
      hit = w.vld && (w.idx == idx);
   endfunction : hit

   logic [1:0] hs_wr;
   logic [FIFO_CW-1:0] mps;
   logic [DESC_W-1:0] mps_d;
   logic ok_end;
   logic ok_data_in;
   logic short_done;
   logic desc_step;
   logic desc_last;
   logic desc_abort;
   logic desc_end;

   assign hs_wr[1] = hit(wr, `EP0C_IDX_IN_HS);
   assign hs_wr[0] = hit(wr, `EP0C_IDX_OUT_HS);
   assign mps = FIFO_CW'(ep0_packet_limit_i);
   assign mps_d = DESC_W'(ep0_packet_limit_i);
   assign ok_end = busy_ff && txn_end_i && txn_ok_i && (resp_ff.hs == HS_DATA) && !txn_setup_ff;
   assign ok_data_in = ok_end && txn_in_ff;
   assign short_done = ok_data_in && (resp_ff.len < ep0_packet_limit_i);
   assign desc_step = ok_data_in && resp_ff.from_desc;
   assign desc_last = desc_step && (descriptor_remaining_size_ff == DESC_W'(resp_ff.len));
   assign desc_abort = descriptor_reply_go_ff && tok_i && (!tok_in_i || tok_setup_i);
   assign desc_end = desc_last || desc_abort;

   // Answer is fixed at the token, so later writes only reach the next one
   always_comb begin
      logic st;
      logic nk;
      st = tok_in_i ? stall_force_ff[1] : stall_force_ff[0];
      nk = tok_in_i ? nak_force_ff[1] : nak_force_ff[0];
      nxt_resp.hs = HS_DATA;
      nxt_resp.len = 7'h00;
      nxt_resp.seq = tok_in_i ? seq_bit_state_ff[1] : seq_bit_state_ff[0];
      nxt_resp.from_desc = 1'b0;
      if (tok_setup_i) begin
         nxt_resp.hs = HS_DATA;
      end else if (st) begin
         nxt_resp.hs = HS_STALL;
      end else if (tok_in_i != ep0_direction_ff) begin
         nxt_resp.hs = HS_NAK;
      end else if (nk) begin
         nxt_resp.hs = HS_NAK;
      end else if (tok_in_i) begin
         if (descriptor_reply_go_ff) begin
            nxt_resp.from_desc = 1'b1;
            nxt_resp.len = (descriptor_remaining_size_ff < mps_d) ?
               descriptor_remaining_size_ff[6:0] : ep0_packet_limit_i;
         end else if (fifo_count_i >= mps) begin
            nxt_resp.len = ep0_packet_limit_i;
         end else if (short_packet_enable_ff) begin
            nxt_resp.len = fifo_count_i[6:0];
         end else begin
            nxt_resp.hs = HS_NAK;
         end
      end else if (fifo_free_i < mps) begin
         nxt_resp.hs = HS_NAK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         busy_ff <= 1'b0;
         txn_in_ff <= 1'b0;
         txn_setup_ff <= 1'b0;
         resp_ff <= '{hs: HS_NAK, len: 7'h00, seq: 1'b0, from_desc: 1'b0};
      end else if (tok_i) begin
         busy_ff <= 1'b1;
         txn_in_ff <= tok_in_i && !tok_setup_i;
         txn_setup_ff <= tok_setup_i;
         resp_ff <= nxt_resp;
      end else if (txn_end_i) begin
         busy_ff <= 1'b0;
      end
   end

   assign resp_o = resp_ff;
   assign busy_o = busy_ff;
   assign descriptor_pointer_o = descriptor_pointer_ff;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ep0_direction_ff <= RST_DIR_DESC[`EP0C_B_DIR];
      end else if (hit(wr, `EP0C_IDX_DIR_DESC)) begin
         ep0_direction_ff <= wr.data[`EP0C_B_DIR];
      end
   end

   // A fresh start from software wins over the hardware end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         descriptor_reply_go_ff <= RST_DIR_DESC[`EP0C_B_REPLY];
      end else if (hit(wr, `EP0C_IDX_DIR_DESC)) begin
         descriptor_reply_go_ff <= wr.data[`EP0C_B_REPLY];
      end else if (desc_end) begin
         descriptor_reply_go_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         descriptor_pointer_ff <= `EP0C_RST_DESC;
         descriptor_remaining_size_ff <= `EP0C_RST_DESC;
      end else begin
         if (hit(wr, `EP0C_IDX_DESC_PTR)) begin
            descriptor_pointer_ff <= wr.data[DESC_W-1:0];
         end else if (desc_step) begin
            descriptor_pointer_ff <= descriptor_pointer_ff + DESC_W'(resp_ff.len);
         end
         if (hit(wr, `EP0C_IDX_DESC_SIZE)) begin
            descriptor_remaining_size_ff <= wr.data[DESC_W-1:0];
         end else if (desc_step) begin
            descriptor_remaining_size_ff <=
               descriptor_remaining_size_ff - DESC_W'(resp_ff.len);
         end
      end
   end

   // Write one clears; a new event in the same cycle keeps the flag set
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         descriptor_done_flag_ff <= 1'b0;
         in_acked_flag_ff <= 1'b0;
      end else begin
         if (desc_end) begin
            descriptor_done_flag_ff <= 1'b1;
            in_acked_flag_ff <= 1'b1;
         end else if (hit(wr, `EP0C_IDX_FLAGS)) begin
            descriptor_done_flag_ff <= descriptor_done_flag_ff & ~wr.data[`EP0C_B_DONE];
            in_acked_flag_ff <= in_acked_flag_ff & ~wr.data[`EP0C_B_INACK];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         short_packet_enable_ff <= RST_IN_HS[`EP0C_B_SHORT];
      end else if (hs_wr[1]) begin
         short_packet_enable_ff <= wr.data[`EP0C_B_SHORT];
      end else if (short_done && !resp_ff.from_desc) begin
         short_packet_enable_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         auto_nak_after_out_ff <= RST_OUT_HS[`EP0C_B_AUTONAK];
      end else if (hs_wr[0]) begin
         auto_nak_after_out_ff <= wr.data[`EP0C_B_AUTONAK];
      end
   end

   for (genvar d = 0; d < 2; d++) begin : g_dir
      logic dir_ok_end;
      logic hw_nak_set;
      logic wd;
      assign dir_ok_end = ok_end && (txn_in_ff == (d == 1));
      assign wd = hs_wr[d];
      if (d == 1) begin : g_in
         assign hw_nak_set = short_done;
      end else begin : g_out
         assign hw_nak_set = dir_ok_end && auto_nak_after_out_ff;
      end

      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            nak_pend_ff[d] <= 1'b0;
         end else if (setup_done_i || (busy_ff && txn_end_i)) begin
            nak_pend_ff[d] <= 1'b0;
         end else if (wd) begin
            nak_pend_ff[d] <= wr.data[`EP0C_B_NAK] && busy_ff;
         end
      end

      // Setup wins, then any set, then an allowed clear
      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            nak_force_ff[d] <= 1'b0;
         end else if (setup_done_i) begin
            nak_force_ff[d] <= 1'b1;
         // A write landing with the end itself must not be lost
         end else if (busy_ff && txn_end_i &&
                      ((wd ? wr.data[`EP0C_B_NAK] : nak_pend_ff[d]) || hw_nak_set)) begin
            nak_force_ff[d] <= 1'b1;
         end else if (wd && wr.data[`EP0C_B_NAK] && !busy_ff) begin
            nak_force_ff[d] <= 1'b1;
         end else if (wd && !wr.data[`EP0C_B_NAK] && !setup_flag_i) begin
            nak_force_ff[d] <= 1'b0;
         end
      end

      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            stall_force_ff[d] <= 1'b0;
         end else if (setup_done_i) begin
            stall_force_ff[d] <= 1'b0;
         end else if (wd && (!wr.data[`EP0C_B_STALL] || !setup_flag_i)) begin
            stall_force_ff[d] <= wr.data[`EP0C_B_STALL];
         end
      end

      // Force-zero over force-one over the hardware flip
      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            seq_bit_state_ff[d] <= 1'b0;
         end else if (setup_done_i) begin
            seq_bit_state_ff[d] <= 1'b1;
         end else if (wd && wr.data[`EP0C_B_SEQ_ZERO]) begin
            seq_bit_state_ff[d] <= 1'b0;
         end else if (wd && wr.data[`EP0C_B_SEQ_ONE]) begin
            seq_bit_state_ff[d] <= 1'b1;
         end else if (dir_ok_end) begin
            seq_bit_state_ff[d] <= ~seq_bit_state_ff[d];
         end
      end
   end

   // Strobe bits read as zero
   always_comb begin
      rd_data = 32'h00000000;
      if (rd_idx == `EP0C_IDX_DIR_DESC) begin
         rd_data[`EP0C_B_DIR] = ep0_direction_ff;
         rd_data[`EP0C_B_REPLY] = descriptor_reply_go_ff;
      end else if (rd_idx == `EP0C_IDX_IN_HS) begin
         rd_data[`EP0C_B_SHORT] = short_packet_enable_ff;
         rd_data[`EP0C_B_SEQ] = seq_bit_state_ff[1];
         rd_data[`EP0C_B_NAK] = nak_force_ff[1];
         rd_data[`EP0C_B_STALL] = stall_force_ff[1];
      end else if (rd_idx == `EP0C_IDX_OUT_HS) begin
         rd_data[`EP0C_B_AUTONAK] = auto_nak_after_out_ff;
         rd_data[`EP0C_B_SEQ] = seq_bit_state_ff[0];
         rd_data[`EP0C_B_NAK] = nak_force_ff[0];
         rd_data[`EP0C_B_STALL] = stall_force_ff[0];
      end else if (rd_idx == `EP0C_IDX_DESC_PTR) begin
         rd_data[DESC_W-1:0] = descriptor_pointer_ff;
      end else if (rd_idx == `EP0C_IDX_DESC_SIZE) begin
         rd_data[DESC_W-1:0] = descriptor_remaining_size_ff;
      end else if (rd_idx == `EP0C_IDX_FLAGS) begin
         rd_data[`EP0C_B_DONE] = descriptor_done_flag_ff;
         rd_data[`EP0C_B_INACK] = in_acked_flag_ff;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_setup;
      setup_done_i;
   endsequence
   sequence s_both_forced;
      (nak_force_ff == 2'b11) && (stall_force_ff == 2'b00) && (seq_bit_state_ff == 2'b11);
   endsequence

   a_stall_first: assert property (tok_i && !tok_setup_i &&
      (tok_in_i ? stall_force_ff[1] : stall_force_ff[0]) |=> resp_o.hs == HS_STALL)
      else $error("stall force not answered with STALL");
   a_dir_nak: assert property (tok_i && !tok_setup_i && (tok_in_i != ep0_direction_ff) &&
      !(tok_in_i ? stall_force_ff[1] : stall_force_ff[0]) |=> resp_o.hs == HS_NAK)
      else $error("wrong direction token not answered with NAK");
   a_forced_nak: assert property (tok_i && !tok_setup_i && (tok_in_i == ep0_direction_ff) &&
      (tok_in_i ? nak_force_ff[1] && !stall_force_ff[1] : nak_force_ff[0] && !stall_force_ff[0])
      |=> resp_o.hs == HS_NAK)
      else $error("forced NAK not answered with NAK");
   a_setup_force: assert property (s_setup |=> s_both_forced)
      else $error("setup did not force NAK and clear STALL");
   a_nak_hold: assert property (setup_flag_i && !setup_done_i && nak_force_ff[1]
      |=> nak_force_ff[1])
      else $error("IN forced NAK cleared while setup flag set");
   a_stall_block: assert property (setup_flag_i && !stall_force_ff[0]
      |=> !stall_force_ff[0])
      else $error("OUT stall force set while setup flag set");
   a_nak_defer: assert property (busy_ff && !txn_end_i && !setup_done_i && hs_wr[1] &&
      wr.data[`EP0C_B_NAK] && !nak_force_ff[1] |=> !nak_force_ff[1])
      else $error("forced NAK took effect mid transaction");
   a_seq_zero: assert property (hs_wr[1] && !setup_done_i && wr.data[`EP0C_B_SEQ_ZERO]
      |=> !seq_bit_state_ff[1])
      else $error("force-zero strobe did not win");
   a_desc_step: assert property (desc_step && !hit(wr, `EP0C_IDX_DESC_PTR) |=>
      descriptor_pointer_ff == $past(descriptor_pointer_ff) + DESC_W'($past(resp_ff.len)))
      else $error("descriptor pointer not advanced by bytes sent");
   a_desc_end: assert property (desc_end && !hit(wr, `EP0C_IDX_DIR_DESC) |=>
      !descriptor_reply_go_ff && descriptor_done_flag_ff && in_acked_flag_ff)
      else $error("descriptor reply end not reported");
   a_short_clr: assert property (short_done && !resp_ff.from_desc && !hs_wr[1]
      |=> !short_packet_enable_ff && nak_force_ff[1])
      else $error("short packet completion not handled");
   a_auto_nak: assert property (g_dir[0].dir_ok_end && auto_nak_after_out_ff
      |=> nak_force_ff[0])
      else $error("auto NAK after OUT missing");
endmodule : ep0c_ctrl
`default_nettype wire

// ==== src/ep0c_pkg.sv ====
// Types shared by the endpoint 0 control block and its bus slave.
// Assumes the constants header is on the include path.
package ep0c_pkg;
   typedef enum logic [1:0] {HS_DATA, HS_NAK, HS_STALL} ep0c_hs_e;
   // Answer chosen at the token, held for the whole transaction
   typedef struct packed {
      ep0c_hs_e hs;
      logic [6:0] len;
      logic seq;
      logic from_desc;
   } ep0c_resp_s;
   // One register write from the bus
   typedef struct packed {
      logic vld;
      logic [7:0] idx;
      logic [31:0] data;
   } ep0c_wr_s;
endpackage : ep0c_pkg

// ==== test/ep0c_host_model.sv ====
// Stand-in for the USB host and engine: issues endpoint 0 tokens and ends them.
// Assumes every task is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ep0c_host_model (
   // Clock
   input wire logic clk_i,
   // Engine events
   output logic tok_o,
   output logic tok_in_o,
   output logic tok_setup_o,
   output logic txn_end_o,
   output logic txn_ok_o,
   output logic setup_done_o,
   output logic setup_flag_o
);
   initial begin
      {tok_o, tok_in_o, tok_setup_o, txn_end_o, txn_ok_o, setup_done_o, setup_flag_o} = '0;
   end
   // Qualifiers flip once released, so a stale value is never trusted
   task automatic start(input logic is_in, input logic is_setup);
      tok_o <= 1'b1;
      tok_in_o <= is_in;
      tok_setup_o <= is_setup;
      @(posedge clk_i);
      tok_o <= 1'b0;
      tok_in_o <= ~is_in;
      tok_setup_o <= ~is_setup;
      @(posedge clk_i);
   endtask : start
   task automatic finish(input logic ok);
      txn_end_o <= 1'b1;
      txn_ok_o <= ok;
      @(posedge clk_i);
      txn_end_o <= 1'b0;
      txn_ok_o <= ~ok;
      @(posedge clk_i);
   endtask : finish
   // The received flag stays up until firmware clears it
   task automatic setup();
      start(1'b0, 1'b1);
      finish(1'b1);
      setup_done_o <= 1'b1;
      setup_flag_o <= 1'b1;
      @(posedge clk_i);
      setup_done_o <= 1'b0;
      @(posedge clk_i);
   endtask : setup
   task automatic clear_flag();
      setup_flag_o <= 1'b0;
      @(posedge clk_i);
   endtask : clear_flag
endmodule : ep0c_host_model
`default_nettype wire

// ==== test/test_usb_ep0_control_endpoint.sv ====
// Self-checking bench for the endpoint 0 control block.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ep0c_consts.svh"
module test_usb_ep0_control_endpoint;
   import ep0c_pkg::*;
   localparam logic [7:0] RD = `EP0C_IDX_DIR_DESC, RI = `EP0C_IDX_IN_HS, RO = `EP0C_IDX_OUT_HS;
   localparam logic [7:0] RP = `EP0C_IDX_DESC_PTR, RS = `EP0C_IDX_DESC_SIZE, RF = `EP0C_IDX_FLAGS;
   logic clk_i, rstn_i, hsel, hwrite, hreadyout, hresp, busy;
   logic tok, tok_in, tok_setup, txn_end, txn_ok, setup_done, setup_flag;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] limit;
   logic [11:0] cnt, free;
   logic [15:0] dptr;
   ep0c_resp_s resp;
   int errors = 0, samples_checked = 0;
   // Model of the two sequence bits, index 1 is IN
   int seqm [2] = '{0, 0};
   ep0c_ctrl u_ep0c_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
      .tok_i(tok), .tok_in_i(tok_in), .tok_setup_i(tok_setup), .txn_end_i(txn_end),
      .txn_ok_i(txn_ok), .setup_done_i(setup_done), .setup_flag_i(setup_flag),
      .ep0_packet_limit_i(limit), .fifo_count_i(cnt), .fifo_free_i(free), .resp_o(resp),
      .busy_o(busy), .descriptor_pointer_o(dptr));
   ep0c_host_model host (.clk_i(clk_i), .tok_o(tok), .tok_in_o(tok_in),
      .tok_setup_o(tok_setup), .txn_end_o(txn_end), .txn_ok_o(txn_ok),
      .setup_done_o(setup_done), .setup_flag_o(setup_flag));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Bounded wait on hready; a stuck bus ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         final_report();
      end
   endtask : wait_ready
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= w;
      hsize <= 3'd2;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, idx, 32'h0, q);
      check($sformatf("register %h", idx), q & m, e);
   endtask : rdchk
   // Reference answer of the endpoint to a token
   function automatic int exp_hs(int is_in, int dir, int stall, int nak);
      if (stall != 0) return HS_STALL;
      if (is_in != dir || nak != 0) return HS_NAK;
      return HS_DATA;
   endfunction : exp_hs
   task automatic tx(input logic is_in, input int hs, input int len, input logic ok);
      host.start(is_in, 1'b0);
      check("handshake", 32'(resp.hs), 32'(hs));
      if (len >= 0) check("length", 32'(resp.len), 32'(len));
      check("sequence", 32'(resp.seq), 32'(seqm[is_in]));
      check("busy", 32'(busy), 32'h1);
      host.finish(ok);
      check("idle", 32'(busy), 32'h0);
      if (ok && hs == HS_DATA) seqm[is_in] ^= 1;
   endtask : tx
   initial begin
      int e, len, ptr, size, fr;
      logic [7:0] ridx [4];
      ridx = '{RD, RI, RO, 8'h7f};
      {rstn_i, hsel, hwrite, haddr, hwdata, htrans, hsize, cnt, free} = '0;
      limit = 7'd64;
      e = $urandom(32'hdbae3517);
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      foreach (ridx[i]) rdchk(ridx[i], 32'hff, 32'h0);
      for (int r = 0; r < 2; r++) begin
         wr(8'(RI + r), 32'h08);
         rdchk(8'(RI + r), 32'h10, 32'h10);
         rdchk(8'(RO - r), 32'h10, 32'h0);
         wr(8'(RI + r), 32'h0c);
         rdchk(8'(RI + r), 32'h10, 32'h0);
      end
      wr(RI, 32'h01);
      wr(RO, 32'h01);
      host.setup();
      seqm = '{1, 1};
      rdchk(RI, 32'h13, 32'h12);
      rdchk(RO, 32'h13, 32'h12);
      wr(RI, 32'h01);
      wr(RO, 32'h01);
      rdchk(RI, 32'h03, 32'h02);
      rdchk(RO, 32'h03, 32'h02);
      host.clear_flag();
      wr(RD, 32'h00);
      wr(RI, 32'h00);
      wr(RO, 32'h00);
      rdchk(RO, 32'h03, 32'h0);
      for (int k = 0; k < 16; k++) begin
         // Level and space straddle one packet, so both FIFO NAK paths come up
         fr = $urandom_range(0, 127);
         cnt <= 12'(127 - fr);
         free <= 12'(fr);
         wr(RD, 32'(k[1]) << 7);
         wr(k[0] ? RI : RO, 32'(k[3:2]));
         e = exp_hs(k[0], k[1], k[2], k[3]);
         if (e == HS_DATA && (k[0] ? (127 - fr) < 64 : fr < 64)) e = HS_NAK;
         tx(k[0], e, (k[0] && e == HS_DATA) ? 64 : -1, 1'b0);
         wr(k[0] ? RI : RO, 32'h0);
      end
      wr(RD, 32'h80);
      for (int k = 0; k < 3; k++) begin
         len = (k == 0) ? 64 : (k == 1) ? $urandom_range(1, 63) : 0;
         cnt <= 12'(len);
         wr(RI, 32'h40);
         tx(1'b1, HS_DATA, len, 1'b1);
         rdchk(RI, 32'h42, (len == 64) ? 32'h40 : 32'h02);
         wr(RI, 32'h0);
      end
      cnt <= 12'd64;
      host.start(1'b1, 1'b0);
      wr(RI, 32'h03);
      check("handshake", 32'(resp.hs), HS_DATA);
      rdchk(RI, 32'h03, 32'h01);
      host.finish(1'b1);
      seqm[1] ^= 1;
      rdchk(RI, 32'h03, 32'h03);
      tx(1'b1, HS_STALL, -1, 1'b1);
      wr(RI, 32'h0);
      ptr = $urandom_range(0, 255);
      size = 64 + $urandom_range(1, 63);
      wr(RP, ptr);
      wr(RS, size);
      wr(RD, 32'h81);
      while (size > 0) begin
         len = (size > 64) ? 64 : size;
         tx(1'b1, HS_DATA, len, 1'b1);
         ptr += len;
         size -= len;
         check("pointer", 32'(dptr), 32'(ptr));
         rdchk(RS, 32'hffff, size);
      end
      rdchk(RD, 32'h01, 32'h0);
      rdchk(RF, 32'h03, 32'h03);
      wr(RF, 32'h03);
      wr(RP, ptr);
      wr(RS, 32'd200);
      wr(RD, 32'h81);
      tx(1'b0, HS_NAK, -1, 1'b1);
      rdchk(RD, 32'h01, 32'h0);
      rdchk(RF, 32'h03, 32'h03);
      wr(RD, 32'h00);
      free <= 12'hfff;
      wr(RO, 32'h80);
      tx(1'b0, HS_DATA, -1, 1'b1);
      rdchk(RO, 32'h82, 32'h82);
      final_report();
   end
endmodule : test_usb_ep0_control_endpoint
`default_nettype wire
